/* File: src/timer_pkg.sv */
/*
 * Constants shared by the auto-reload timer and its clock helpers:
 * register addresses, control field positions, reset values and
 * the prescaler ratio.
 * Assumes an 8-bit special function register port with byte addresses.
 */
package timer_pkg;

    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_CONTROL = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

    // Field positions inside the control register
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IE = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_EXT_SEL = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Value read from an unmapped address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Byte value at which a counter byte wraps
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

    // System clock prescaler ratio for the slow count clock
    localparam int PRESCALE_DIV = 12;

endpackage

/* File: src/tick_if.sv */
/*
 * Count-enable pulses passed from the clock helpers to the timer core.
 * Assumes every signal is a one-cycle pulse on the system clock.
 */
interface tick_if;
    logic div12_tick;
    logic ext_rise;
    logic ext_fall;

    // Prescaler drives the slow tick
    modport pre (output div12_tick);
    // Synchroniser drives the external clock edges
    modport sync (output ext_rise, output ext_fall);
    // Timer core consumes all of them
    modport sink (input div12_tick, input ext_rise, input ext_fall);
endinterface

/* File: src/div12_prescaler.sv */
/*
 * System clock prescaler: one-cycle enable pulse every DIV clocks.
 * Assumes a single system clock and an asynchronous active-low reset.
 */
module div12_prescaler #(
    parameter int DIV = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick output
    tick_if.pre tk
);
    localparam int W = $clog2(DIV);

    // A ratio below two would leave no room for a counter
    if (DIV < 2) begin : g_bad_div
        $error("Prescaler ratio must be at least two");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // Next count; the tick is registered so it is glitch free
    always_comb begin
        if (cnt_q == W'(DIV - 1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + W'(1);
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.div12_tick = tick_q;
endmodule

/* File: src/ext_edge_sync.sv */
/*
 * Brings the external oscillator divided by 8 into the system clock
 * domain and marks its rising and falling edges with one-cycle pulses.
 * Assumes the external clock is slower than half the system clock.
 */
module ext_edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous divided oscillator
    input wire logic ext_clk,
    // Edge pulses
    tick_if.sync tk
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic last_q;
    logic last_d;

    // Two-flop synchroniser, then a history flop for edge detection
    always_comb begin
        meta_d = ext_clk;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // Only the settled stages are compared, never the first flop
    assign tk.ext_rise = sync_q & ~last_q;
    assign tk.ext_fall = ~sync_q & last_q;
endmodule

/* File: src/auto_reload_timer_with_capture.sv */
/*
 * Timer core: 16-bit auto-reload timer, split into two 8-bit timers
 * on request, with external oscillator capture and overflow flags.
 * Assumes the clock control bits and the interrupt enable come from
 * logic on the same clock, and the divided oscillator is asynchronous.
 */
module auto_reload_timer_with_capture
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Special function register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Clock select bits held in the clock control register
    input wire logic HIGH_BYTE_CLK_SEL,
    input wire logic LOW_BYTE_CLK_SEL,
    // Timer interrupt enable from the interrupt controller
    input wire logic TIMER_INT_EN,
    // External oscillator divided by 8
    input wire logic EXT_CLK_DIV8,
    // Interrupt request
    output logic TIMER_IRQ
);
    tick_if ticks ();

    // Slow tick at one twelfth of the system clock
    div12_prescaler #(
        .DIV(PRESCALE_DIV)
    ) u_prescaler (
        .clk(CLK),
        .rst_n(RST_N),
        .tk(ticks.pre)
    );

    // Resynchronised external clock edges
    ext_edge_sync u_ext_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .ext_clk(EXT_CLK_DIV8),
        .tk(ticks.sync)
    );

    // Control fields
    logic high_flag_q;
    logic high_flag_d;
    logic low_flag_q;
    logic low_flag_d;
    logic low_ie_q;
    logic low_ie_d;
    logic cap_en_q;
    logic cap_en_d;
    logic split_q;
    logic split_d;
    logic run_q;
    logic run_d;
    logic ext_sel_q;
    logic ext_sel_d;

    // Counter and reload bytes
    logic [7:0] cnt_low_q;
    logic [7:0] cnt_low_d;
    logic [7:0] cnt_high_q;
    logic [7:0] cnt_high_d;
    logic [7:0] rl_low_q;
    logic [7:0] rl_low_d;
    logic [7:0] rl_high_q;
    logic [7:0] rl_high_d;

    // Read data and interrupt
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_q;
    logic irq_d;

    // Write decode
    logic wr_ctrl;
    logic wr_rl_low;
    logic wr_rl_high;
    logic wr_cnt_low;
    logic wr_cnt_high;

    // Count enables and events
    logic tick_low;
    logic tick_high;
    logic inc_low;
    logic inc_high;
    logic wrap_low;
    logic wrap_high;
    logic capture;

    // Address decode of write strobes
    always_comb begin
        wr_ctrl = 1'b0;
        wr_rl_low = 1'b0;
        wr_rl_high = 1'b0;
        wr_cnt_low = 1'b0;
        wr_cnt_high = 1'b0;
        if (!SFR_WR) begin
            wr_ctrl = 1'b0;
        end else if (SFR_ADDR == ADDR_CONTROL) begin
            wr_ctrl = 1'b1;
        end else if (SFR_ADDR == ADDR_RELOAD_LOW) begin
            wr_rl_low = 1'b1;
        end else if (SFR_ADDR == ADDR_RELOAD_HIGH) begin
            wr_rl_high = 1'b1;
        end else if (SFR_ADDR == ADDR_COUNT_LOW) begin
            wr_cnt_low = 1'b1;
        end else if (SFR_ADDR == ADDR_COUNT_HIGH) begin
            wr_cnt_high = 1'b1;
        end
    end

    // Per-byte count clock; the low select also serves 16-bit mode, capture takes the external fall directly
    always_comb begin
        tick_low = LOW_BYTE_CLK_SEL ? 1'b1 : (ext_sel_q ? ticks.ext_rise : ticks.div12_tick);
        tick_high = HIGH_BYTE_CLK_SEL ? 1'b1 : (ext_sel_q ? ticks.ext_rise : ticks.div12_tick);
    end

    // Counter, reload and flag next state
    always_comb begin
        cnt_low_d = cnt_low_q;
        cnt_high_d = cnt_high_q;
        rl_low_d = rl_low_q;
        rl_high_d = rl_high_q;
        // Low byte free-runs in split mode, run bit gates it otherwise
        inc_low = split_q ? tick_low : (run_q && tick_low);
        // High byte: own clock in split mode, carry of the low byte otherwise
        inc_high = split_q ? (run_q && tick_high) : (inc_low && cnt_low_q == BYTE_ALL_ONES);
        wrap_low = inc_low && (cnt_low_q == BYTE_ALL_ONES);
        wrap_high = inc_high && (cnt_high_q == BYTE_ALL_ONES);
        if (inc_low) begin
            cnt_low_d = cnt_low_q + 8'h01;
        end
        if (inc_high) begin
            cnt_high_d = cnt_high_q + 8'h01;
        end
        if (split_q) begin
            // Each byte reloads from its own reload byte
            if (wrap_low) begin
                cnt_low_d = rl_low_q;
            end
            if (wrap_high) begin
                cnt_high_d = rl_high_q;
            end
        end else if (wrap_high) begin
            // Full 16-bit wrap reloads both bytes
            cnt_low_d = rl_low_q;
            cnt_high_d = rl_high_q;
        end
        // Capture snapshots the counter as it stood this cycle
        capture = cap_en_q && ticks.ext_fall;
        if (capture) begin
            rl_low_d = cnt_low_q;
            rl_high_d = cnt_high_q;
        end
        // A software write takes the byte over from the hardware
        if (wr_rl_low) begin
            rl_low_d = SFR_WDATA;
        end
        if (wr_rl_high) begin
            rl_high_d = SFR_WDATA;
        end
        if (wr_cnt_low) begin
            cnt_low_d = SFR_WDATA;
        end
        if (wr_cnt_high) begin
            cnt_high_d = SFR_WDATA;
        end
    end

    // Control register; hardware set beats a software clear in the same cycle
    always_comb begin
        low_ie_d = low_ie_q;
        cap_en_d = cap_en_q;
        split_d = split_q;
        run_d = run_q;
        ext_sel_d = ext_sel_q;
        high_flag_d = high_flag_q;
        low_flag_d = low_flag_q;
        if (wr_ctrl) begin
            high_flag_d = SFR_WDATA[BIT_HIGH_FLAG];
            low_flag_d = SFR_WDATA[BIT_LOW_FLAG];
            low_ie_d = SFR_WDATA[BIT_LOW_IE];
            cap_en_d = SFR_WDATA[BIT_CAPTURE_EN];
            split_d = SFR_WDATA[BIT_SPLIT];
            run_d = SFR_WDATA[BIT_RUN];
            ext_sel_d = SFR_WDATA[BIT_EXT_SEL];
        end
        // Flags set by hardware here; a control write can also set them
        if (wrap_high || capture) begin
            high_flag_d = 1'b1;
        end
        if (wrap_low) begin
            low_flag_d = 1'b1;
        end
    end

    // Read mux and interrupt level; unused bit 1 reads zero
    always_comb begin
        if (SFR_ADDR == ADDR_CONTROL) begin
            rdata_d = {high_flag_q, low_flag_q, low_ie_q, cap_en_q, split_q, run_q, 1'b0, ext_sel_q};
        end else if (SFR_ADDR == ADDR_RELOAD_LOW) begin
            rdata_d = rl_low_q;
        end else if (SFR_ADDR == ADDR_RELOAD_HIGH) begin
            rdata_d = rl_high_q;
        end else if (SFR_ADDR == ADDR_COUNT_LOW) begin
            rdata_d = cnt_low_q;
        end else if (SFR_ADDR == ADDR_COUNT_HIGH) begin
            rdata_d = cnt_high_q;
        end else begin
            rdata_d = UNMAPPED_READ;
        end
        // Level request: held while a flag that may interrupt is set
        irq_d = TIMER_INT_EN && (high_flag_q || (low_ie_q && low_flag_q));
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            high_flag_q <= CONTROL_RESET[BIT_HIGH_FLAG];
            low_flag_q <= CONTROL_RESET[BIT_LOW_FLAG];
            low_ie_q <= CONTROL_RESET[BIT_LOW_IE];
            cap_en_q <= CONTROL_RESET[BIT_CAPTURE_EN];
            split_q <= CONTROL_RESET[BIT_SPLIT];
            run_q <= CONTROL_RESET[BIT_RUN];
            ext_sel_q <= CONTROL_RESET[BIT_EXT_SEL];
            cnt_low_q <= BYTE_RESET;
            cnt_high_q <= BYTE_RESET;
            rl_low_q <= BYTE_RESET;
            rl_high_q <= BYTE_RESET;
            rdata_q <= UNMAPPED_READ;
            irq_q <= 1'b0;
        end else begin
            high_flag_q <= high_flag_d;
            low_flag_q <= low_flag_d;
            low_ie_q <= low_ie_d;
            cap_en_q <= cap_en_d;
            split_q <= split_d;
            run_q <= run_d;
            ext_sel_q <= ext_sel_d;
            cnt_low_q <= cnt_low_d;
            cnt_high_q <= cnt_high_d;
            rl_low_q <= rl_low_d;
            rl_high_q <= rl_high_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign SFR_RDATA = rdata_q;
    assign TIMER_IRQ = irq_q;

    // Checks on the timer behaviour
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_wrap16;
        !split_q && run_q && tick_low && {cnt_high_q, cnt_low_q} == 16'hffff && !wr_cnt_low && !wr_cnt_high
        |=> {cnt_high_q, cnt_low_q} == $past({rl_high_q, rl_low_q}) && high_flag_q && low_flag_q;
    endproperty
    a_wrap16: assert property (p_wrap16) else $error("16-bit wrap did not reload and flag");

    property p_hold16;
        !split_q && !run_q && !wr_cnt_low && !wr_cnt_high |=> $stable({cnt_high_q, cnt_low_q});
    endproperty
    a_hold16: assert property (p_hold16) else $error("Stopped 16-bit counter moved");

    property p_split_low_runs;
        split_q && !run_q && tick_low && cnt_low_q != BYTE_ALL_ONES && !wr_cnt_low && !wr_cnt_high
        |=> cnt_low_q == $past(cnt_low_q) + 8'h01 && $stable(cnt_high_q);
    endproperty
    a_split_low_runs: assert property (p_split_low_runs) else $error("Split low byte not free running");

    property p_split_high_wrap;
        split_q && run_q && tick_high && cnt_high_q == BYTE_ALL_ONES && !wr_cnt_high
        |=> cnt_high_q == $past(rl_high_q) && high_flag_q;
    endproperty
    a_split_high_wrap: assert property (p_split_high_wrap) else $error("Split high wrap wrong");

    property p_low_flag;
        (split_q || run_q) && tick_low && cnt_low_q == BYTE_ALL_ONES |=> low_flag_q;
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("Low wrap did not set low flag");

    property p_sticky;
        high_flag_q && !wr_ctrl ##1 !wr_ctrl |=> high_flag_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("High flag cleared without a write");

    property p_capture;
        cap_en_q && ticks.ext_fall && !wr_rl_low && !wr_rl_high
        |=> {rl_high_q, rl_low_q} == $past({cnt_high_q, cnt_low_q}) && high_flag_q;
    endproperty
    a_capture: assert property (p_capture) else $error("Capture did not copy the counter");

    property p_irq;
        TIMER_INT_EN && (high_flag_q || low_ie_q && low_flag_q) |=> TIMER_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not raised");

    property p_irq_cause;
        TIMER_IRQ |-> $past(TIMER_INT_EN) && ($past(high_flag_q) || $past(low_ie_q && low_flag_q));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("Interrupt without a cause");

    property p_one_edge;
        ticks.ext_rise |=> !ticks.ext_rise;
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("External edge counted twice");

    c_wrap16: cover property (!split_q && wrap_high);
    c_split_both: cover property (split_q && wrap_low ##[1:600] split_q && wrap_high);
    c_capture: cover property (capture ##[1:600] capture);
endmodule

/* File: dv/auto_reload_timer_with_capture_test.sv */
/*
 * Self-checking bench for the auto-reload timer: register access,
 * 16-bit and split counting, capture, flags and interrupt request.
 * Assumes the timer package and all design sources are compiled first.
 */
module auto_reload_timer_with_capture_test ();
    timeunit 1ns;
    timeprecision 1ps;
    import timer_pkg::*;

    // Stimulus and observed outputs
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0;
    logic hsel = 1'b0;
    logic lsel = 1'b0;
    logic int_en = 1'b0;
    logic ext = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] rdata;
    logic irq;
    logic [31:0] seed = 32'h25173d01;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    auto_reload_timer_with_capture dut_u (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
        .SFR_WDATA(sfr_wdata), .SFR_RDATA(rdata), .HIGH_BYTE_CLK_SEL(hsel), .LOW_BYTE_CLK_SEL(lsel),
        .TIMER_INT_EN(int_en), .EXT_CLK_DIV8(ext), .TIMER_IRQ(irq));

    // 50 MHz system clock
    always #10 clk = ~clk;

    // Edges since reset release; gives the free-running prescaler phase
    always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // 16-bit reference: {high flag, low flag, count} after n ticks
    function automatic logic [17:0] m16(logic [15:0] c, logic [15:0] rl, int n);
        logic fh;
        logic fl;
        fh = 1'b0;
        fl = 1'b0;
        repeat (n) begin
            fl |= (c[7:0] == BYTE_ALL_ONES);
            fh |= (c == 16'hffff);
            c = (c == 16'hffff) ? rl : c + 16'h0001;
        end
        return {fh, fl, c};
    endfunction

    // 8-bit reference: {flag, count} after n ticks
    function automatic logic [8:0] m8(logic [7:0] c, logic [7:0] rl, int n);
        logic f;
        f = 1'b0;
        repeat (n) begin
            f |= (c == BYTE_ALL_ONES);
            c = (c == BYTE_ALL_ONES) ? rl : c + 8'h01;
        end
        return {f, c};
    endfunction

    task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One write, taken at the second edge
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wr <= 1'b1;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // Read data is registered, so sample one edge after the address lands
    task automatic rchk(string name, logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        @(posedge clk);
        @(negedge clk);
        chk(name, {8'h00, rdata}, {8'h00, exp});
    endtask

    // Select bit used as a gate: exactly n system-clock ticks, no register write
    task automatic tick(logic high, int n);
        @(posedge clk);
        if (high) hsel <= 1'b1;
        else lsel <= 1'b1;
        repeat (n) @(posedge clk);
        hsel <= 1'b0;
        lsel <= 1'b0;
    endtask

    // Slow external pulse, long enough for the synchroniser to see both edges
    task automatic ext_pulse();
        @(posedge clk);
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        ext <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] c;
        logic [17:0] e;
        logic [8:0] e8;
        logic [7:0] hb;
        int n;
        int s;
        int x;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h90; a <= 8'h96; a++) begin
            rchk("reset", a[7:0], 8'h00);
        end
        for (int a = 8'h92; a <= 8'h96; a++) begin
            r = rnd();
            wr(a[7:0], r[7:0]);
            rchk("rw", a[7:0], (a == 8'h96) ? UNMAPPED_READ : r[7:0]);
        end
        wr(ADDR_CONTROL, 8'hfe);
        rchk("ctrl_rw", ADDR_CONTROL, 8'hfc);
        // Interrupt request against every flag and enable mix
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_CONTROL, {i[2:0], 5'h00});
            int_en <= i[3];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("irq_mix", {15'h0, irq}, {15'h0, i[3] & (i[2] | (i[1] & i[0]))});
        end
        // 16-bit wraps near the top of the count, external source idle
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            c = r[0] ? {13'h1fff, r[3:1]} : {r[15:8], 8'hf8};
            n = 1 + int'(r[7:4]);
            wr(ADDR_CONTROL, {2'b00, k[0], 5'h05});
            wr(ADDR_RELOAD_LOW, r[23:16]);
            wr(ADDR_RELOAD_HIGH, r[31:24]);
            wr(ADDR_COUNT_LOW, c[7:0]);
            wr(ADDR_COUNT_HIGH, c[15:8]);
            tick(1'b0, n);
            e = m16(c, r[31:16], n);
            rchk("cnt_lo", ADDR_COUNT_LOW, e[7:0]);
            rchk("cnt_hi", ADDR_COUNT_HIGH, e[15:8]);
            rchk("ctrl16", ADDR_CONTROL, {e[17:16], k[0], 5'h05});
            chk("irq16", {15'h0, irq}, {15'h0, e[17] | (k[0] & e[16])});
        end
        // Run bit clear: the system-clock select alone must not move the count
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_COUNT_LOW, 8'h5a);
        tick(1'b0, 8);
        rchk("hold", ADDR_COUNT_LOW, 8'h5a);
        // Divide-by-12 source: a 50-edge window holds four or five ticks
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_CONTROL, 8'h04);
        // Run is seen set on the 50 edges that follow; slow tick lands on edge 12m+1
        s = cyc + 2;
        repeat (48) @(posedge clk);
        wr(ADDR_CONTROL, 8'h00);
        x = 0;
        for (int j = s; j < s + 50; j++) begin
            if (j % PRESCALE_DIV == 1) x++;
        end
        @(posedge clk);
        sfr_addr <= ADDR_COUNT_LOW;
        repeat (2) @(negedge clk);
        chk("div12", {8'h00, rdata}, x[15:0]);
        // Split mode: high byte on system clock under run
        r = rnd();
        n = 4 + int'(r[18:16]);
        wr(ADDR_RELOAD_HIGH, r[7:0]);
        wr(ADDR_COUNT_HIGH, 8'hfc);
        wr(ADDR_COUNT_LOW, r[15:8]);
        wr(ADDR_CONTROL, 8'h0d);
        tick(1'b1, n);
        e8 = m8(8'hfc, r[7:0], n);
        hb = e8[7:0];
        rchk("split_hi", ADDR_COUNT_HIGH, e8[7:0]);
        rchk("split_lo", ADDR_COUNT_LOW, r[15:8]);
        repeat (20) @(posedge clk);
        rchk("split_ctrl", ADDR_CONTROL, {e8[8], 7'h0d});
        chk("irq_split", {15'h0, irq}, {15'h0, e8[8]});
        // Split mode, run clear: low byte still counts external rising edges
        wr(ADDR_CONTROL, 8'h09);
        wr(ADDR_RELOAD_LOW, 8'h80);
        wr(ADDR_COUNT_LOW, 8'hfd);
        repeat (5) ext_pulse();
        e8 = m8(8'hfd, 8'h80, 5);
        rchk("ext_lo", ADDR_COUNT_LOW, e8[7:0]);
        rchk("ext_hi", ADDR_COUNT_HIGH, hb);
        rchk("no_cap", ADDR_RELOAD_LOW, 8'h80);
        rchk("ext_ctrl", ADDR_CONTROL, {1'b0, e8[8], 6'h09});
        chk("irq_lo_off", {15'h0, irq}, 16'h0000);
        wr(ADDR_CONTROL, 8'h69);
        rchk("ctrl_lo_ie", ADDR_CONTROL, 8'h69);
        chk("irq_lo_on", {15'h0, irq}, 16'h0001);
        // Capture on the falling edge of the external clock
        r = rnd();
        wr(ADDR_CONTROL, 8'h10); // Split clear while capturing
        wr(ADDR_COUNT_LOW, r[7:0]);
        wr(ADDR_COUNT_HIGH, r[15:8]);
        ext_pulse();
        rchk("cap_lo", ADDR_RELOAD_LOW, r[7:0]);
        rchk("cap_hi", ADDR_RELOAD_HIGH, r[15:8]);
        rchk("cap_ctrl", ADDR_CONTROL, 8'h90);
        finish_test();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule
